// *** vip_pkg.sv ***
// package: constants, types and helpers for the vectored interrupt controller
`default_nettype none
package vip_pkg;
    localparam int          NUM_SRC        = 32;
    localparam int          NUM_SLOT       = 16;
    localparam int          SRC_W          = 5;
    localparam int          SLOT_W         = 4;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;
    localparam int          WDOG_CHAN      = 0;
    localparam int          SOFT_CHAN      = 1;

    localparam logic [11:0] OFF_IRQ_STATUS = 12'h000;
    localparam logic [11:0] OFF_FIQ_STATUS = 12'h004;
    localparam logic [11:0] OFF_RAW_STATUS = 12'h008;
    localparam logic [11:0] OFF_INT_SELECT = 12'h00c;
    localparam logic [11:0] OFF_INT_ENABLE = 12'h010;
    localparam logic [11:0] OFF_ENABLE_CLR = 12'h014;
    localparam logic [11:0] OFF_SOFT_INT   = 12'h018;
    localparam logic [11:0] OFF_SOFT_CLR   = 12'h01c;
    localparam logic [11:0] OFF_VECT_ADDR  = 12'h030;
    localparam logic [11:0] OFF_DEF_VECT   = 12'h034;
    localparam logic [11:0] OFF_CUR_SLOT   = 12'h038;
    localparam logic [11:0] OFF_SLOT_ADDR  = 12'h100;
    localparam logic [11:0] OFF_SLOT_CNTL  = 12'h200;

    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam int          CNTL_EN_BIT    = 5;
    localparam int          CUR_ANY_BIT    = 4;

    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_DECERR    = 2'b11;

    typedef struct packed {
        logic             en;
        logic [SRC_W-1:0] src;
    } vip_cntl_t;

    localparam vip_cntl_t   RST_CNTL       = '{en: 1'b0, src: 5'h00};

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } vip_wr_t;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b00,
        WR_APPLY   = 2'b01,
        WR_RESP    = 2'b11
    } vip_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,
        RD_FETCH = 2'b01,
        RD_RESP  = 2'b11
    } vip_rd_state_t;

    // byte-lane merge of a write into an old register value
    function automatic logic [31:0] vip_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // true when the address falls in a 16-word slot table at base
    function automatic logic vip_in_table(input logic [11:0] addr,
                                          input logic [11:0] base);
        return (addr[11:6] == base[11:6]) && (addr[1:0] == 2'b00);
    endfunction
endpackage
`default_nettype wire

// *** vip_slot_arb.sv ***
// slot arbiter: picks the lowest-numbered enabled slot whose source requests
`timescale 1ns/1ps
`default_nettype none
module vip_slot_arb
(
    input  wire logic [31:0]                 i_irq_stat,
    input  wire vip_pkg::vip_cntl_t [15:0]   i_cntl,
    output logic                             o_any,
    output logic [3:0]                       o_idx
);
    logic [15:0] slot_req;

    always_comb
    begin
        for (int n = 0; n < vip_pkg::NUM_SLOT; n++)
        begin
            slot_req[n] = i_cntl[n].en & i_irq_stat[i_cntl[n].src];
        end
    end

    // scan from the lowest priority up so slot 0 wins last
    always_comb
    begin
        o_any = |slot_req;
        o_idx = 4'h0;
        for (int n = vip_pkg::NUM_SLOT - 1; n >= 0; n--)
        begin
            if (slot_req[n])
            begin
                o_idx = n[3:0];
            end
        end
    end
endmodule
`default_nettype wire

// *** vip_axil_wr.sv ***
// write-channel collector: takes address and data in either order
`timescale 1ns/1ps
`default_nettype none
module vip_axil_wr
(
    input  wire logic            i_sys_clk,
    input  wire logic            i_rst,
    input  wire logic            i_awvalid,
    output logic                 o_awready,
    input  wire logic [11:0]     i_awaddr,
    input  wire logic            i_wvalid,
    output logic                 o_wready,
    input  wire logic [31:0]     i_wdata,
    input  wire logic [3:0]      i_wstrb,
    output logic                 o_bvalid,
    input  wire logic            i_bready,
    output logic [1:0]           o_bresp,
    output vip_pkg::vip_wr_t     o_wr,
    output logic                 o_wr_fire,
    input  wire logic            i_wr_err
);
    vip_pkg::vip_wr_state_t state_r;
    logic                   aw_have_r;
    logic                   w_have_r;
    logic [11:0]            addr_r;
    logic [31:0]            data_r;
    logic [3:0]             strb_r;

    // one driver for the whole carrier struct
    assign o_wr = '{addr: addr_r, data: data_r, strb: strb_r};

    assign o_awready = (state_r == vip_pkg::WR_COLLECT) && !aw_have_r;
    assign o_wready  = (state_r == vip_pkg::WR_COLLECT) && !w_have_r;
    assign o_bvalid  = (state_r == vip_pkg::WR_RESP);
    assign o_wr_fire = (state_r == vip_pkg::WR_APPLY);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            aw_have_r   <= 1'b0;
            addr_r      <= 12'h000;
        end
        else if (i_awvalid && o_awready)
        begin
            aw_have_r   <= 1'b1;
            addr_r      <= i_awaddr;
        end
        else if (o_bvalid && i_bready)
        begin
            aw_have_r   <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            w_have_r    <= 1'b0;
            data_r      <= vip_pkg::RST_WORD;
            strb_r      <= 4'h0;
        end
        else if (i_wvalid && o_wready)
        begin
            w_have_r    <= 1'b1;
            data_r      <= i_wdata;
            strb_r      <= i_wstrb;
        end
        else if (o_bvalid && i_bready)
        begin
            w_have_r    <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            state_r <= vip_pkg::WR_COLLECT;
            o_bresp <= vip_pkg::RESP_OKAY;
        end
        else
        begin
            case (state_r)
                vip_pkg::WR_COLLECT:
                begin
                    if (aw_have_r && w_have_r)
                    begin
                        state_r <= vip_pkg::WR_APPLY;
                    end
                end
                vip_pkg::WR_APPLY:
                begin
                    state_r <= vip_pkg::WR_RESP;
                    o_bresp <= i_wr_err ? vip_pkg::RESP_DECERR : vip_pkg::RESP_OKAY;
                end
                vip_pkg::WR_RESP:
                begin
                    if (i_bready)
                    begin
                        state_r <= vip_pkg::WR_COLLECT;
                    end
                end
                default:
                begin
                    state_r <= vip_pkg::WR_COLLECT;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** vip_vectored_irq_controller.sv ***
// vectored interrupt controller with an AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vip_vectored_irq_controller
(
    input  wire logic            i_sys_clk,
    input  wire logic            i_rst,
    input  wire logic [31:0]     i_irq_src,
    output logic                 o_fast_interrupt_request,
    output logic                 o_irq,
    input  wire logic            i_awvalid,
    output logic                 o_awready,
    input  wire logic [11:0]     i_awaddr,
    input  wire logic            i_wvalid,
    output logic                 o_wready,
    input  wire logic [31:0]     i_wdata,
    input  wire logic [3:0]      i_wstrb,
    output logic                 o_bvalid,
    input  wire logic            i_bready,
    output logic [1:0]           o_bresp,
    input  wire logic            i_arvalid,
    output logic                 o_arready,
    input  wire logic [11:0]     i_araddr,
    output logic                 o_rvalid,
    input  wire logic            i_rready,
    output logic [31:0]          o_rdata,
    output logic [1:0]           o_rresp
);
    logic [31:0]                 int_select_r;
    logic [31:0]                 int_enable_r;
    logic                        soft_int_r;
    logic [31:0]                 def_vect_r;
    logic [31:0]                 slot_addr_r [16];
    vip_pkg::vip_cntl_t [15:0]   slot_cntl_r;

    logic [31:0]                 raw_stat;
    logic [31:0]                 fast_stat;
    logic [31:0]                 irq_stat;
    logic                        slot_any;
    logic [3:0]                  slot_idx;
    logic [31:0]                 vect_now;

    vip_pkg::vip_wr_t            wr;
    logic                        wr_fire;
    logic                        wr_err;
    logic [3:0]                  wr_slot;

    vip_pkg::vip_rd_state_t      rd_state_r;
    logic [11:0]                 rd_addr_r;
    logic [31:0]                 rd_word;
    logic                        rd_err;
    logic [3:0]                  rd_slot;

    // register map decode shared by reads and writes
    function automatic logic is_mapped(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        if (a == vip_pkg::OFF_IRQ_STATUS || a == vip_pkg::OFF_FIQ_STATUS)
        begin
            hit = 1'b1;
        end
        else if (a == vip_pkg::OFF_RAW_STATUS || a == vip_pkg::OFF_INT_SELECT)
        begin
            hit = 1'b1;
        end
        else if (a == vip_pkg::OFF_INT_ENABLE || a == vip_pkg::OFF_ENABLE_CLR)
        begin
            hit = 1'b1;
        end
        else if (a == vip_pkg::OFF_SOFT_INT || a == vip_pkg::OFF_SOFT_CLR)
        begin
            hit = 1'b1;
        end
        else if (a == vip_pkg::OFF_VECT_ADDR || a == vip_pkg::OFF_DEF_VECT)
        begin
            hit = 1'b1;
        end
        else if (a == vip_pkg::OFF_CUR_SLOT)
        begin
            hit = 1'b1;
        end
        else if (vip_pkg::vip_in_table(a, vip_pkg::OFF_SLOT_ADDR))
        begin
            hit = 1'b1;
        end
        else if (vip_pkg::vip_in_table(a, vip_pkg::OFF_SLOT_CNTL))
        begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // request gathering and classification
    always_comb
    begin
        raw_stat = i_irq_src;
        raw_stat[vip_pkg::SOFT_CHAN] = soft_int_r;
        fast_stat = raw_stat & int_enable_r & int_select_r;
        irq_stat  = raw_stat & int_enable_r & ~int_select_r;
    end

    vip_slot_arb u_slot_arb
    (
        .i_irq_stat (irq_stat),
        .i_cntl     (slot_cntl_r),
        .o_any      (slot_any),
        .o_idx      (slot_idx)
    );

    // winner address or shared default
    assign vect_now = slot_any ? slot_addr_r[slot_idx] : def_vect_r;

    // level outputs, registered, follow their sources each cycle
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_fast_interrupt_request <= 1'b0;
            o_irq                    <= 1'b0;
        end
        else
        begin
            o_fast_interrupt_request <= |fast_stat;
            o_irq                    <= |irq_stat;
        end
    end

    // write channel
    vip_axil_wr u_axil_wr
    (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_awvalid  (i_awvalid),
        .o_awready  (o_awready),
        .i_awaddr   (i_awaddr),
        .i_wvalid   (i_wvalid),
        .o_wready   (o_wready),
        .i_wdata    (i_wdata),
        .i_wstrb    (i_wstrb),
        .o_bvalid   (o_bvalid),
        .i_bready   (i_bready),
        .o_bresp    (o_bresp),
        .o_wr       (wr),
        .o_wr_fire  (wr_fire),
        .i_wr_err   (wr_err)
    );

    assign wr_err  = !is_mapped(wr.addr);
    assign wr_slot = wr.addr[5:2];

    // class selection and enables
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            int_select_r <= vip_pkg::RST_WORD;
            int_enable_r <= vip_pkg::RST_WORD;
        end
        else if (wr_fire)
        begin
            if (wr.addr == vip_pkg::OFF_INT_SELECT)
            begin
                int_select_r <= vip_pkg::vip_merge(int_select_r, wr.data, wr.strb);
            end
            else if (wr.addr == vip_pkg::OFF_INT_ENABLE)
            begin
                int_enable_r <= int_enable_r
                              | vip_pkg::vip_merge(32'h0000_0000, wr.data, wr.strb);
            end
            else if (wr.addr == vip_pkg::OFF_ENABLE_CLR)
            begin
                int_enable_r <= int_enable_r
                              & ~vip_pkg::vip_merge(32'h0000_0000, wr.data, wr.strb);
            end
        end
    end

    // software-generated request on its reserved channel
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            soft_int_r <= 1'b0;
        end
        else if (wr_fire && wr.strb[0])
        begin
            if (wr.addr == vip_pkg::OFF_SOFT_INT && wr.data[vip_pkg::SOFT_CHAN])
            begin
                soft_int_r <= 1'b1;
            end
            else if (wr.addr == vip_pkg::OFF_SOFT_CLR && wr.data[vip_pkg::SOFT_CHAN])
            begin
                soft_int_r <= 1'b0;
            end
        end
    end

    // default handler address
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            def_vect_r <= vip_pkg::RST_WORD;
        end
        else if (wr_fire && wr.addr == vip_pkg::OFF_DEF_VECT)
        begin
            def_vect_r <= vip_pkg::vip_merge(def_vect_r, wr.data, wr.strb);
        end
    end

    // slot handler addresses
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            for (int n = 0; n < vip_pkg::NUM_SLOT; n++)
            begin
                slot_addr_r[n] <= vip_pkg::RST_WORD;
            end
        end
        else if (wr_fire && vip_pkg::vip_in_table(wr.addr, vip_pkg::OFF_SLOT_ADDR))
        begin
            slot_addr_r[wr_slot] <= vip_pkg::vip_merge(slot_addr_r[wr_slot],
                                                       wr.data, wr.strb);
        end
    end

    // slot control: enable and source number
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            for (int n = 0; n < vip_pkg::NUM_SLOT; n++)
            begin
                slot_cntl_r[n] <= vip_pkg::RST_CNTL;
            end
        end
        else if (wr_fire && wr.strb[0]
                 && vip_pkg::vip_in_table(wr.addr, vip_pkg::OFF_SLOT_CNTL))
        begin
            slot_cntl_r[wr_slot].en  <= wr.data[vip_pkg::CNTL_EN_BIT];
            slot_cntl_r[wr_slot].src <= wr.data[vip_pkg::SRC_W-1:0];
        end
    end

    // read channel
    assign o_arready = (rd_state_r == vip_pkg::RD_IDLE);
    assign o_rvalid  = (rd_state_r == vip_pkg::RD_RESP);
    assign rd_slot   = rd_addr_r[5:2];
    assign rd_err    = !is_mapped(rd_addr_r);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (rd_addr_r == vip_pkg::OFF_IRQ_STATUS)
        begin
            rd_word = irq_stat;
        end
        else if (rd_addr_r == vip_pkg::OFF_FIQ_STATUS)
        begin
            rd_word = fast_stat;
        end
        else if (rd_addr_r == vip_pkg::OFF_RAW_STATUS)
        begin
            rd_word = raw_stat;
        end
        else if (rd_addr_r == vip_pkg::OFF_INT_SELECT)
        begin
            rd_word = int_select_r;
        end
        else if (rd_addr_r == vip_pkg::OFF_INT_ENABLE)
        begin
            rd_word = int_enable_r;
        end
        else if (rd_addr_r == vip_pkg::OFF_SOFT_INT)
        begin
            rd_word[vip_pkg::SOFT_CHAN] = soft_int_r;
        end
        else if (rd_addr_r == vip_pkg::OFF_VECT_ADDR)
        begin
            rd_word = vect_now;
        end
        else if (rd_addr_r == vip_pkg::OFF_DEF_VECT)
        begin
            rd_word = def_vect_r;
        end
        else if (rd_addr_r == vip_pkg::OFF_CUR_SLOT)
        begin
            rd_word[vip_pkg::CUR_ANY_BIT] = slot_any;
            rd_word[3:0]                  = slot_idx;
        end
        else if (vip_pkg::vip_in_table(rd_addr_r, vip_pkg::OFF_SLOT_ADDR))
        begin
            rd_word = slot_addr_r[rd_slot];
        end
        else if (vip_pkg::vip_in_table(rd_addr_r, vip_pkg::OFF_SLOT_CNTL))
        begin
            rd_word[vip_pkg::CNTL_EN_BIT]    = slot_cntl_r[rd_slot].en;
            rd_word[vip_pkg::SRC_W-1:0]      = slot_cntl_r[rd_slot].src;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            rd_state_r <= vip_pkg::RD_IDLE;
            rd_addr_r  <= 12'h000;
            o_rdata    <= vip_pkg::RST_WORD;
            o_rresp    <= vip_pkg::RESP_OKAY;
        end
        else
        begin
            case (rd_state_r)
                vip_pkg::RD_IDLE:
                begin
                    if (i_arvalid)
                    begin
                        rd_addr_r  <= i_araddr;
                        rd_state_r <= vip_pkg::RD_FETCH;
                    end
                end
                vip_pkg::RD_FETCH:
                begin
                    o_rdata    <= rd_word;
                    o_rresp    <= rd_err ? vip_pkg::RESP_DECERR : vip_pkg::RESP_OKAY;
                    rd_state_r <= vip_pkg::RD_RESP;
                end
                vip_pkg::RD_RESP:
                begin
                    if (i_rready)
                    begin
                        rd_state_r <= vip_pkg::RD_IDLE;
                    end
                end
                default:
                begin
                    rd_state_r <= vip_pkg::RD_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** vip_core_model.sv ***
// core model: counts entries into fast and normal interrupt service
`timescale 1ns/1ps
`default_nettype none
module vip_core_model
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_fast,
    input  wire logic       i_irq,
    output logic [7:0]      o_fast_cnt,
    output logic [7:0]      o_irq_cnt
);
    logic fast_r;
    logic irq_r;
    always_ff @(posedge i_sys_clk)
    begin
        fast_r <= i_fast;
        irq_r  <= i_irq;
    end
    // a service entry is a rising level on either line
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_fast_cnt <= 8'h00;
            o_irq_cnt  <= 8'h00;
        end
        else
        begin
            o_fast_cnt <= o_fast_cnt + 8'(i_fast && !fast_r);
            o_irq_cnt  <= o_irq_cnt + 8'(i_irq && !irq_r);
        end
    end
endmodule
`default_nettype wire

// *** vip_ctrl_chk.sv ***
// checker: bus timing and interrupt output properties of the controller
`timescale 1ns/1ps
`default_nettype none
module vip_ctrl_chk
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic [31:0] i_irq_src,
    input wire logic        o_fast_interrupt_request,
    input wire logic        o_irq,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_rst_quiet;
        $fell(i_rst) |-> !o_fast_interrupt_request && !o_irq;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output high after reset");
    // no source change and no register update: outputs hold
    property p_hold_lvl;
        $stable(i_irq_src) && $past(o_awready) |=>
            $stable(o_irq) && $stable(o_fast_interrupt_request);
    endproperty
    a_hold_lvl: assert property (p_hold_lvl) else $error("output moved without cause");
    property p_r_lat;
        i_arvalid && o_arready |=> !o_rvalid ##1 o_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_b_lat;
        i_awvalid && o_awready && i_wvalid && o_wready |=> !o_bvalid [*2] ##1 o_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_r_block;
        o_rvalid |-> !o_arready;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read taken while busy");
    property p_b_block;
        o_bvalid |-> !o_awready && !o_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while busy");
    property p_r_back;
        o_rvalid && i_rready |=> !o_rvalid && o_arready;
    endproperty
    a_r_back: assert property (p_r_back) else $error("read channel not freed");
    property p_b_back;
        o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready;
    endproperty
    a_b_back: assert property (p_b_back) else $error("write channel not freed");
    property p_dec_zero;
        o_rvalid && o_rresp == vip_pkg::RESP_DECERR |-> o_rdata == 32'h0;
    endproperty
    a_dec_zero: assert property (p_dec_zero) else $error("unmapped read data not zero");
endmodule
bind vip_vectored_irq_controller vip_ctrl_chk i_chk (.*);
`default_nettype wire

// *** tb_top.sv ***
// testbench: register accesses and request patterns for the controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [1:0] OK = vip_pkg::RESP_OKAY;
    localparam logic [11:0] OFFS [8] = '{vip_pkg::OFF_IRQ_STATUS, vip_pkg::OFF_FIQ_STATUS,
        vip_pkg::OFF_RAW_STATUS, vip_pkg::OFF_INT_SELECT, vip_pkg::OFF_INT_ENABLE,
        vip_pkg::OFF_VECT_ADDR, vip_pkg::OFF_DEF_VECT, vip_pkg::OFF_SLOT_CNTL};
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [31:0] i_irq_src = '0;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic [11:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0, msk;
    logic [3:0]  i_wstrb = 4'hf;
    logic        o_fast_interrupt_request, o_irq, o_awready, o_wready;
    logic        o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [7:0]  fast_cnt, irq_cnt;
    int          fails = 0, cmp_count = 0, cyc = 0;
    always #2.5 i_sys_clk = ~i_sys_clk;
    vip_vectored_irq_controller i_dut (.*);
    vip_core_model i_core (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_fast(o_fast_interrupt_request), .i_irq(o_irq), .o_fast_cnt(fast_cnt),
        .o_irq_cnt(irq_cnt));
    function automatic logic [31:0] hnd(input int n);
        return 32'h0000_a000 + 32'(16 * n);
    endfunction
    task automatic stop_test;
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b = 1'b0;
        @(posedge i_sys_clk);
        i_awaddr  <= a;
        i_wdata   <= d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        while (!b)
        begin
            @(negedge i_sys_clk);
            aw = i_awvalid && o_awready;
            w  = i_wvalid && o_wready;
            b  = o_bvalid;
            if (b)
                chk("bresp", 32'(er), 32'(o_bresp));
            @(posedge i_sys_clk);
            if (aw)
                i_awvalid <= 1'b0;
            if (w)
                i_wvalid <= 1'b0;
        end
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar, r = 1'b0;
        @(posedge i_sys_clk);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        while (!r)
        begin
            @(negedge i_sys_clk);
            ar = i_arvalid && o_arready;
            r  = o_rvalid;
            if (r)
            begin
                chk("rdata", e, o_rdata);
                chk("rresp", 32'(er), 32'(o_rresp));
            end
            @(posedge i_sys_clk);
            if (ar)
                i_arvalid <= 1'b0;
        end
        i_rready <= 1'b0;
    endtask
    // drive request lines, let them settle, compare both outputs
    task automatic look(input logic [31:0] s, input logic ef, input logic ei);
        @(posedge i_sys_clk);
        i_irq_src <= s;
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("fast", 32'(ef), 32'(o_fast_interrupt_request));
        chk("irq", 32'(ei), 32'(o_irq));
    endtask
    always @(posedge i_sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        look(32'h0, 1'b0, 1'b0);
        foreach (OFFS[i])
            rd(OFFS[i], 32'h0, OK);
        rd(12'h040, 32'h0, vip_pkg::RESP_DECERR);
        wr(12'h040, 32'h1, vip_pkg::RESP_DECERR);
        wr(vip_pkg::OFF_DEF_VECT, 32'h0000_d000, OK);
        for (int n = 0; n < vip_pkg::NUM_SLOT; n++)
        begin
            wr(vip_pkg::OFF_SLOT_ADDR + 12'(4 * n), hnd(n), OK);
            wr(vip_pkg::OFF_SLOT_CNTL + 12'(4 * n), 32'h20 | 32'(n + 2), OK);
        end
        rd(12'h23c, 32'h31, OK);
        rd(vip_pkg::OFF_SLOT_ADDR + 12'h03c, hnd(15), OK);
        wr(vip_pkg::OFF_INT_ENABLE, 32'hffff_ffff, OK);
        look(32'h0010_0001, 1'b0, 1'b1);
        rd(vip_pkg::OFF_VECT_ADDR, 32'h0000_d000, OK);
        rd(vip_pkg::OFF_IRQ_STATUS, 32'h0010_0001, OK);
        rd(vip_pkg::OFF_RAW_STATUS, 32'h0010_0001, OK);
        msk = 32'h0010_0000;
        for (int k = 15; k >= 0; k--)
        begin
            msk = msk | (32'h4 << k);
            look(msk, 1'b0, 1'b1);
            rd(vip_pkg::OFF_VECT_ADDR, hnd(k), OK);
        end
        rd(vip_pkg::OFF_CUR_SLOT, 32'h10, OK);
        look(32'h0, 1'b0, 1'b0);
        look(32'h10, 1'b0, 1'b1);
        wr(vip_pkg::OFF_ENABLE_CLR, 32'h10, OK);
        look(32'h10, 1'b0, 1'b0);
        rd(vip_pkg::OFF_INT_ENABLE, 32'hffff_ffef, OK);
        wr(vip_pkg::OFF_INT_ENABLE, 32'h10, OK);
        wr(vip_pkg::OFF_INT_SELECT, 32'h0010_0008, OK);
        look(32'h8, 1'b1, 1'b0);
        rd(vip_pkg::OFF_FIQ_STATUS, 32'h8, OK);
        look(32'h0010_0018, 1'b1, 1'b1);
        rd(vip_pkg::OFF_FIQ_STATUS, 32'h0010_0008, OK);
        rd(vip_pkg::OFF_VECT_ADDR, hnd(2), OK);
        rd(vip_pkg::OFF_IRQ_STATUS, 32'h10, OK);
        wr(vip_pkg::OFF_INT_SELECT, 32'h0010_0000, OK);
        look(32'h0010_0018, 1'b1, 1'b1);
        rd(vip_pkg::OFF_VECT_ADDR, hnd(1), OK);
        look(32'h0, 1'b0, 1'b0);
        look(32'h2, 1'b0, 1'b0);
        wr(vip_pkg::OFF_SOFT_INT, 32'h2, OK);
        look(32'h2, 1'b0, 1'b1);
        rd(vip_pkg::OFF_SOFT_INT, 32'h2, OK);
        wr(vip_pkg::OFF_SOFT_CLR, 32'h2, OK);
        look(32'h0, 1'b0, 1'b0);
        chk("fast entries", 32'h1, 32'(fast_cnt));
        chk("irq entries", 32'h5, 32'(irq_cnt));
        stop_test();
    end
endmodule
`default_nettype wire
